// [hdl/occ_pkg.sv]
// occ_pkg: constants and types for the upper channel group output control registers.
// assumes a 32-bit AHB-Lite slave port and four serial output lines, channels 13 to 16.
package occ_pkg;
    localparam int OCC_ADDR_W = 12;
    localparam int OCC_SAMPLE_W = 14;
    localparam int OCC_NCH = 4;
    // register indices; byte address is four times the index
    localparam logic [9:0] OCC_PDI_IDX = 10'h03C;
    localparam logic [9:0] OCC_DLY_IDX = 10'h043;
    localparam logic [15:0] OCC_PDI_RST = 16'h0000;
    localparam logic [3:0] OCC_SKEW_RST = 4'h0;
    // field positions, channel 13 at the lsb of each group
    localparam int OCC_DIG_LSB = 12;
    localparam int OCC_LINE_LSB = 8;
    localparam int OCC_ANA_LSB = 4;
    localparam int OCC_FLIP_LSB = 0;
    localparam int OCC_SKEW_LSB = 1;
    localparam int OCC_SKEW_W = 4;
    // skew step in picoseconds
    localparam logic signed [10:0] OCC_STEP_PS = 11'sh06E;

    typedef struct packed {
        logic [OCC_NCH-1:0] dig_off;
        logic [OCC_NCH-1:0] line_off;
        logic [OCC_NCH-1:0] ana_off;
        logic [OCC_NCH-1:0] flip;
    } occ_ctrl_t;

    typedef struct packed {
        logic hready;
        logic hresp;
        logic wr_pend;
        logic [9:0] widx;
        logic [15:0] pdi;
        logic [OCC_SKEW_W-1:0] skew;
        logic signed [10:0] skew_ps;
        logic [31:0] rdata;
        logic [OCC_NCH-1:0][OCC_SAMPLE_W-1:0] dout;
    } occ_state_t;
endpackage

// [hdl/occ_regs.sv]
// occ_regs: power-down, data inversion and bit clock skew registers for channels 13 to 16,
// reached over an AHB-Lite slave port, plus the per-line output data gating and inversion.
// assumes one master, hready fed back from HREADYOUT, samples synchronous to MCLK.
//
// Functional notes
// - bits 15..12 power down digital block of channels 16..13 when 1
// - bits 11..8 power down serial output lines 16..13 when 1
// - bits 7..4 power down analog block of channels 16..13 when 1
// - bit 3 inverts sample data on serial line 16
// - bit 2 inverts sample data on serial line 15
// - bits 1 and 0 invert data on lines 14 and 13
// - all power-down and inversion bits read zero after reset
// - skew field bits 4..1 shifts bit clock in 110 ps steps
// - skew field is signed twos complement, 1111 is minus one step
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module occ_regs
    import occ_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [OCC_ADDR_W-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [OCC_NCH-1:0][OCC_SAMPLE_W-1:0] SAMPLE_IN,
    output logic [OCC_NCH-1:0][OCC_SAMPLE_W-1:0] SERIAL_DATA,
    output occ_ctrl_t CHAN_CTRL,
    output logic [OCC_SKEW_W-1:0] BIT_CLOCK_SKEW_CODE,
    output logic signed [10:0] BIT_CLOCK_SKEW_PS
);
    localparam occ_state_t OCC_STATE_RST = '{
        hready: 1'b1,
        hresp: 1'b0,
        wr_pend: 1'b0,
        widx: '0,
        pdi: OCC_PDI_RST,
        skew: OCC_SKEW_RST,
        skew_ps: '0,
        rdata: '0,
        dout: '0
    };

    occ_state_t st_q;
    occ_state_t st_d;
    logic take;

    // zero wait states, so every valid address phase is taken
    assign take = HSEL & HREADY & HTRANS[1];

    always_comb begin
        st_d = st_q;
        st_d.hready = 1'b1;
        st_d.hresp = 1'b0;
        // data phase of a write lands here
        if (st_q.wr_pend) begin
            if (st_q.widx == OCC_PDI_IDX) begin
                st_d.pdi = HWDATA[15:0];
            end else if (st_q.widx == OCC_DLY_IDX) begin
                // only the skew field is kept, other bits always read zero
                st_d.skew = HWDATA[OCC_SKEW_LSB +: OCC_SKEW_W];
            end
        end
        // signed code times step covers -8..+7 steps linearly
        st_d.skew_ps = $signed(st_d.skew) * OCC_STEP_PS;
        st_d.wr_pend = take & HWRITE;
        st_d.widx = HADDR[OCC_ADDR_W-1:2];
        st_d.rdata = '0;
        // read data built from the next values so a write just before is seen
        if (take && !HWRITE) begin
            if (HADDR[OCC_ADDR_W-1:2] == OCC_PDI_IDX) begin
                st_d.rdata = {16'h0000, st_d.pdi};
            end else if (HADDR[OCC_ADDR_W-1:2] == OCC_DLY_IDX) begin
                st_d.rdata = {27'h0000000, st_d.skew, 1'b0};
            end
        end
        for (int i = 0; i < OCC_NCH; i++) begin
            // a line with its digital block or driver off sends zeros
            if (st_d.pdi[OCC_DIG_LSB+i] || st_d.pdi[OCC_LINE_LSB+i]) begin
                st_d.dout[i] = '0;
            end else begin
                st_d.dout[i] = SAMPLE_IN[i]
                    ^ {OCC_SAMPLE_W{st_d.pdi[OCC_FLIP_LSB+i]}};
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            st_q <= OCC_STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign HRDATA = st_q.rdata;
    assign HREADYOUT = st_q.hready;
    assign HRESP = st_q.hresp;
    assign SERIAL_DATA = st_q.dout;
    assign CHAN_CTRL.dig_off = st_q.pdi[OCC_DIG_LSB +: OCC_NCH];
    assign CHAN_CTRL.line_off = st_q.pdi[OCC_LINE_LSB +: OCC_NCH];
    assign CHAN_CTRL.ana_off = st_q.pdi[OCC_ANA_LSB +: OCC_NCH];
    assign CHAN_CTRL.flip = st_q.pdi[OCC_FLIP_LSB +: OCC_NCH];
    assign BIT_CLOCK_SKEW_CODE = st_q.skew;
    assign BIT_CLOCK_SKEW_PS = st_q.skew_ps;

    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    logic wr_pdi;
    logic wr_dly;
    logic rd_dly;
    logic rd_dly_q;
    assign wr_pdi = st_q.wr_pend && (st_q.widx == OCC_PDI_IDX);
    assign wr_dly = st_q.wr_pend && (st_q.widx == OCC_DLY_IDX);
    assign rd_dly = take && !HWRITE && (HADDR[OCC_ADDR_W-1:2] == OCC_DLY_IDX);
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rd_dly_q <= 1'b0;
        end else begin
            rd_dly_q <= rd_dly;
        end
    end

    property p_dig_off;
        wr_pdi |=> CHAN_CTRL.dig_off == $past(HWDATA[15:12]);
    endproperty
    a_dig_off: assert property (p_dig_off) else $error("digital off bits wrong");

    property p_line_off;
        wr_pdi |=> CHAN_CTRL.line_off == $past(HWDATA[11:8]);
    endproperty
    a_line_off: assert property (p_line_off) else $error("line off bits wrong");

    property p_ana_off;
        wr_pdi |=> CHAN_CTRL.ana_off == $past(HWDATA[7:4]);
    endproperty
    a_ana_off: assert property (p_ana_off) else $error("analog off bits wrong");

    property p_flip16;
        !st_d.pdi[11] && !st_d.pdi[15] |=> SERIAL_DATA[3] == ($past(SAMPLE_IN[3])
            ^ {OCC_SAMPLE_W{$past(st_d.pdi[3])}});
    endproperty
    a_flip16: assert property (p_flip16) else $error("line 16 polarity wrong");

    property p_flip15;
        !st_d.pdi[10] && !st_d.pdi[14] |=> SERIAL_DATA[2] == ($past(SAMPLE_IN[2])
            ^ {OCC_SAMPLE_W{$past(st_d.pdi[2])}});
    endproperty
    a_flip15: assert property (p_flip15) else $error("line 15 polarity wrong");

    property p_flip_low;
        wr_pdi |=> CHAN_CTRL.flip[1:0] == $past(HWDATA[1:0]);
    endproperty
    a_flip_low: assert property (p_flip_low) else $error("line 14/13 flip wrong");

    property p_reset_zero;
        $past(SYS_RST) |-> st_q.pdi == 16'h0000 && st_q.skew == 4'h0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("not zero after reset");

    property p_skew_scale;
        wr_dly |=> BIT_CLOCK_SKEW_PS == $signed($past(HWDATA[4:1])) * OCC_STEP_PS;
    endproperty
    a_skew_scale: assert property (p_skew_scale) else $error("skew scale wrong");

    property p_skew_minus;
        BIT_CLOCK_SKEW_CODE == 4'hF |-> BIT_CLOCK_SKEW_PS == -11'sd110;
    endproperty
    a_skew_minus: assert property (p_skew_minus) else $error("minus one step wrong");

    property p_skew_range;
        BIT_CLOCK_SKEW_PS >= -11'sd880 && BIT_CLOCK_SKEW_PS <= 11'sd770;
    endproperty
    a_skew_range: assert property (p_skew_range) else $error("skew out of range");

    property p_dly_zero_bits;
        rd_dly_q |-> HRDATA[31:5] == '0 && HRDATA[0] == 1'b0;
    endproperty
    a_dly_zero_bits: assert property (p_dly_zero_bits) else $error("unused bits set");

    property p_cov_write;
        wr_pdi ##1 CHAN_CTRL.dig_off != 4'h0;
    endproperty
    c_cov_write: cover property (p_cov_write);

    property p_cov_neg_skew;
        wr_dly ##1 BIT_CLOCK_SKEW_PS < 11'sd0;
    endproperty
    c_cov_neg_skew: cover property (p_cov_neg_skew);

    property p_cov_read;
        rd_dly ##1 HRDATA[4:1] != 4'h0;
    endproperty
    c_cov_read: cover property (p_cov_read);

    property p_cov_line_off;
        wr_pdi ##1 CHAN_CTRL.line_off != 4'h0;
    endproperty
    c_cov_line_off: cover property (p_cov_line_off);

    property p_cov_flip;
        wr_pdi ##1 CHAN_CTRL.flip != 4'h0;
    endproperty
    c_cov_flip: cover property (p_cov_flip);

    // bus side: the slave never stalls and never errors, so a master may stream
    // transfers back to back; read data only stands in the data phase of a read
    property p_hready_one;
        HREADYOUT == 1'b1;
    endproperty
    a_hready_one: assert property (p_hready_one) else $error("slave stalled");

    property p_hresp_okay;
        HRESP == 1'b0;
    endproperty
    a_hresp_okay: assert property (p_hresp_okay) else $error("slave error response");

    property p_rdata_idle;
        !take |=> HRDATA == 32'h00000000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside data phase");

    property p_rdata_unmapped;
        take && !HWRITE && (HADDR[OCC_ADDR_W-1:2] != OCC_PDI_IDX)
            && (HADDR[OCC_ADDR_W-1:2] != OCC_DLY_IDX) |=> HRDATA == 32'h00000000;
    endproperty
    a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("unmapped read not zero");

    property p_pdi_read;
        take && !HWRITE && (HADDR[OCC_ADDR_W-1:2] == OCC_PDI_IDX)
            |=> HRDATA == {16'h0000, CHAN_CTRL};
    endproperty
    a_pdi_read: assert property (p_pdi_read) else $error("pdi read back wrong");

    property p_pdi_hold;
        !wr_pdi |=> $stable(CHAN_CTRL);
    endproperty
    a_pdi_hold: assert property (p_pdi_hold) else $error("pdi changed without write");

    property p_flip14;
        !st_d.pdi[9] && !st_d.pdi[13] |=> SERIAL_DATA[1] == ($past(SAMPLE_IN[1])
            ^ {OCC_SAMPLE_W{$past(st_d.pdi[1])}});
    endproperty
    a_flip14: assert property (p_flip14) else $error("line 14 polarity wrong");

    property p_flip13;
        !st_d.pdi[8] && !st_d.pdi[12] |=> SERIAL_DATA[0] == ($past(SAMPLE_IN[0])
            ^ {OCC_SAMPLE_W{$past(st_d.pdi[0])}});
    endproperty
    a_flip13: assert property (p_flip13) else $error("line 13 polarity wrong");

    // analog power-down must never gate the digital stream of its line
    for (genvar g = 0; g < OCC_NCH; g++) begin : g_line_chk
        property p_line_zero;
            st_d.pdi[OCC_DIG_LSB+g] || st_d.pdi[OCC_LINE_LSB+g] |=> SERIAL_DATA[g] == '0;
        endproperty
        a_line_zero: assert property (p_line_zero) else $error("off line not zero");

        property p_ana_pass;
            !st_d.pdi[OCC_DIG_LSB+g] && !st_d.pdi[OCC_LINE_LSB+g] && !st_d.pdi[OCC_FLIP_LSB+g]
                |=> SERIAL_DATA[g] == $past(SAMPLE_IN[g]);
        endproperty
        a_ana_pass: assert property (p_ana_pass) else $error("line data not passed");
    end

    property p_skew_hold;
        !wr_dly |=> $stable(BIT_CLOCK_SKEW_CODE);
    endproperty
    a_skew_hold: assert property (p_skew_hold) else $error("skew changed without write");

    property p_skew_zero;
        BIT_CLOCK_SKEW_CODE == 4'h0 |-> BIT_CLOCK_SKEW_PS == 11'sd0;
    endproperty
    a_skew_zero: assert property (p_skew_zero) else $error("zero code not zero delay");

    property p_skew_plus2;
        BIT_CLOCK_SKEW_CODE == 4'h2 |-> BIT_CLOCK_SKEW_PS == 11'sd220;
    endproperty
    a_skew_plus2: assert property (p_skew_plus2) else $error("plus two steps wrong");

    property p_skew_minus2;
        BIT_CLOCK_SKEW_CODE == 4'hE |-> BIT_CLOCK_SKEW_PS == -11'sd220;
    endproperty
    a_skew_minus2: assert property (p_skew_minus2) else $error("minus two steps wrong");

    property p_skew_max;
        BIT_CLOCK_SKEW_CODE == 4'h7 |-> BIT_CLOCK_SKEW_PS == 11'sd770;
    endproperty
    a_skew_max: assert property (p_skew_max) else $error("largest positive skew wrong");

    property p_skew_min;
        BIT_CLOCK_SKEW_CODE == 4'h8 |-> BIT_CLOCK_SKEW_PS == -11'sd880;
    endproperty
    a_skew_min: assert property (p_skew_min) else $error("largest negative skew wrong");

    property p_dly_read;
        rd_dly_q |-> HRDATA[4:1] == BIT_CLOCK_SKEW_CODE;
    endproperty
    a_dly_read: assert property (p_dly_read) else $error("skew read back wrong");
endmodule

// [dv/occ_regs_test.sv]
// occ_regs_test: register and data path bench for the channel 13-16 output controls.
// assumes occ_regs is the only slave, with this bench as the sole AHB-Lite master.
`timescale 1ns/1ps
module occ_regs_test;
    import occ_pkg::*;
    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic HSEL = 1'b0;
    logic [OCC_ADDR_W-1:0] HADDR = 12'h000;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA;
    logic HREADYOUT;
    logic HRESP;
    logic [OCC_NCH-1:0][OCC_SAMPLE_W-1:0] SAMPLE_IN = {14'h2A5C, 14'h1234, 14'h3F01, 14'h0ABC};
    logic [OCC_NCH-1:0][OCC_SAMPLE_W-1:0] SERIAL_DATA;
    occ_ctrl_t CHAN_CTRL;
    logic [OCC_SKEW_W-1:0] BIT_CLOCK_SKEW_CODE;
    logic signed [10:0] BIT_CLOCK_SKEW_PS;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rd;

    always #5 MCLK = ~MCLK;

    occ_regs i_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .SAMPLE_IN(SAMPLE_IN), .SERIAL_DATA(SERIAL_DATA), .CHAN_CTRL(CHAN_CTRL),
        .BIT_CLOCK_SKEW_CODE(BIT_CLOCK_SKEW_CODE), .BIT_CLOCK_SKEW_PS(BIT_CLOCK_SKEW_PS));

    task automatic end_sim;
        if (failures == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // waits on hready in both phases instead of assuming a zero-wait slave
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= wr;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HSEL <= 1'b0;
        HWDATA <= wd;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
        chk("hresp", {31'h0, HRESP}, 32'h0);
    endtask

    task automatic rst_seq;
        SYS_RST <= 1'b1;
        repeat (5) @(posedge MCLK);
        SYS_RST <= 1'b0;
        @(posedge MCLK);
    endtask

    function automatic logic [31:0] line_exp(input logic [15:0] v, input int i);
        if (v[12+i] || v[8+i])
            return 32'h0;
        return {18'h0, SAMPLE_IN[i] ^ {OCC_SAMPLE_W{v[i]}}};
    endfunction

    task automatic set_pdi(input logic [31:0] wv, input logic [15:0] v);
        xfer(1'b1, 12'h0F0, wv);
        xfer(1'b0, 12'h0F0, 32'h0);
        chk("pdi_read", rd, {16'h0, v});
        @(posedge MCLK);
        #1;
        chk("chan_ctrl", {16'h0, CHAN_CTRL}, {16'h0, v});
        for (int i = 0; i < OCC_NCH; i++) begin
            chk("serial_data", 32'(SERIAL_DATA[i]), line_exp(v, i));
        end
    endtask

    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            end_sim;
        end
    end

    initial begin
        int e;
        rst_seq;
        for (int r = 0; r < 2; r++) begin
            xfer(1'b0, 12'h0F0, 32'h0);
            chk("pdi_reset", rd, 32'h0);
            xfer(1'b0, 12'h10C, 32'h0);
            chk("skew_reset", rd, 32'h0);
            chk("ctrl_reset", {16'h0, CHAN_CTRL}, 32'h0);
            if (r == 0) begin
                for (int b = 0; b < 16; b++) begin
                    set_pdi(32'h1 << b, 16'h1 << b);
                end
                set_pdi(32'h0000A5C3, 16'hA5C3);
                set_pdi(32'hABCD1234, 16'h1234);
                // software keeps the reserved skew bits at zero
                for (int c = 0; c < 16; c++) begin
                    xfer(1'b1, 12'h10C, 32'(c) << 1);
                    xfer(1'b0, 12'h10C, 32'h0);
                    chk("skew_read", rd, 32'(c) << 1);
                    @(posedge MCLK);
                    #1;
                    e = (c >= 8) ? c - 16 : c;
                    chk("skew_code", {28'h0, BIT_CLOCK_SKEW_CODE}, 32'(c));
                    chk("skew_ps", 32'(BIT_CLOCK_SKEW_PS), 32'(e * 110));
                end
                xfer(1'b1, 12'h0F4, 32'hFFFFFFFF);
                xfer(1'b0, 12'h0F4, 32'h0);
                chk("unmapped", rd, 32'h0);
                rst_seq;
            end
        end
        end_sim;
    end
endmodule
